// ---- logic/dcu_regs.vh ----
`ifndef DCU_REGS_VH
`define DCU_REGS_VH

// avalon word addresses of the command port
`define DCU_A_CMD        2'h0
`define DCU_A_DATA       2'h1
`define DCU_A_STAT       2'h2

// command codes handled here
`define DCU_C_SLEEP_IN   8'h10
`define DCU_C_SLEEP_OUT  8'h11
`define DCU_C_HORI_SET   8'hb4
`define DCU_C_VERT_SET   8'hb6
`define DCU_C_PCONF_SET  8'hb8
`define DCU_C_PVAL_SET   8'hba
`define DCU_C_PSTAT_GET  8'hbb
`define DCU_C_POST_SET   8'hbc
`define DCU_C_PWM_SET    8'hbe
`define DCU_C_GEN0_SET   8'hc0
`define DCU_C_GEN3_SET   8'hc6
`define DCU_C_LOGIC0_SET 8'hc8
`define DCU_C_LOGIC3_SET 8'hce
`define DCU_C_ABC_SET    8'hd0
`define DCU_C_THR_SET    8'hd4
`define DCU_C_PLL_START  8'he0
`define DCU_C_PLL_SET    8'he2
`define DCU_C_PLL_STAT   8'he4
`define DCU_C_DEEP_SLEEP 8'he5
`define DCU_C_PCLK_SET   8'he6
`define DCU_C_FMT_SET    8'hf0

// parameter slots in the byte store, 16 bytes each
`define DCU_S_HORI       5'h00
`define DCU_S_VERT       5'h01
`define DCU_S_PCONF      5'h02
`define DCU_S_PVAL       5'h03
`define DCU_S_POST       5'h04
`define DCU_S_PWM        5'h05
`define DCU_S_GEN0       5'h06
`define DCU_S_LOGIC0     5'h0a
`define DCU_S_ABC        5'h0e
`define DCU_S_THR        5'h0f
`define DCU_S_PLL        5'h10
`define DCU_S_PCLK       5'h11
`define DCU_S_FMT        5'h12
`define DCU_S_START      5'h13
`define DCU_S_NONE       5'h1f
`define DCU_SLOTS        20
`define DCU_SLOT_BYTES   16

// field positions
`define DCU_F_PLL_EN     0
`define DCU_F_PLL_USE    1
`define DCU_F_GEN0_USE   0
`define DCU_F_FMT_MSB    2
`define DCU_ST_LOCK      0
`define DCU_ST_PLL_EN    1
`define DCU_ST_PLL_USE   2
`define DCU_ST_DEEP      3
`define DCU_ST_SLEEP     4

// reset values
`define DCU_RST_BYTE     8'h00
`define DCU_RST_FMT      3'h0

`endif

// ---- logic/dcu_cmd_decoder.v ----
`timescale 1ns/1ns
`include "dcu_regs.vh"

// Overview of operation
// - B5 returns the stored horizontal front-porch and period bytes.
// - B6 stores vertical blanking settings; B7 returns them.
// - B8 sets per-pin panel use and direction; panel pins follow signal logic.
// - B9 returns the pin configuration last written by B8.
// - BA sets the driven level of pins configured as outputs.
// - BB reports live level for input pins, programmed value otherwise.
// - BC/BD store and return post-processor; BE/BF store and return backlight pwm.
// - C0, C2, C4, C6 store settings of signal generators zero to three.
// - C1, C3, C5, C7 return settings of signal generators zero to three.
// - C8..CE set pin logic function of generators; ignored on general pins.
// - C9..CF return pin logic settings of pins zero to three.
// - D0 stores backlight control configuration; D1 returns it.
// - D4 stores power-saving thresholds; D5 returns them.
// - E0 starts the pll; before that logic runs from crystal clock.
// - E2 stores pll multiplier/divider, E3 returns them, E4 reports lock.
// - E5 places the device into deep sleep.
// - E6 stores pixel clock frequency setting; E7 returns it.
// - F0 selects host pixel data format; F1 returns it.
// - sleep entry drives pin zero low unless pin zero is general or panel use.
module dcu_cmd_decoder #(
  parameter NPIN = 4
) (
  input  wire            clk_i,            // 100 MHz clock
  input  wire            rst_i,            // async reset, active high
  input  wire [1:0]      avs_address_i,    // word address
  input  wire            avs_read_i,       // read request
  input  wire            avs_write_i,      // write request
  input  wire [7:0]      avs_writedata_i,  // write byte
  output reg  [7:0]      avs_readdata_o,   // read byte
  output reg             avs_waitrequest_o, // low for the answering cycle
  input  wire [NPIN-1:0] gpio_in_i,        // pin input levels, asynchronous
  output reg  [NPIN-1:0] gpio_o,           // pin output levels
  output reg  [NPIN-1:0] gpio_oe_o,        // pin output enables, high drives
  input  wire [3:0]      gen_sig_i,        // signal generator outputs, same clock
  input  wire            pll_locked_i,     // pll lock, asynchronous
  output reg             pll_en_o,         // pll powered
  output reg             pll_sel_o,        // system clock taken from pll
  output reg             deep_sleep_o,     // deep sleep state
  output reg             sleep_o,          // panel sleep state
  output reg  [2:0]      pix_fmt_o         // host pixel data format
);

  localparam MEMW = `DCU_SLOTS * `DCU_SLOT_BYTES;

  reg  [7:0]      pmem [0:MEMW-1];
  reg  [7:0]      cmd_reg;
  reg  [3:0]      idx_reg;
  reg  [NPIN-1:0] panel_reg;
  reg  [NPIN-1:0] dir_reg;
  reg             gen0_use_reg;
  reg  [NPIN-1:0] val_reg;
  reg  [5:0]      sel_reg [0:NPIN-1];
  reg  [7:0]      fn_reg  [0:NPIN-1];
  reg  [NPIN-1:0] pin_meta_reg;
  reg  [NPIN-1:0] pin_sync_reg;
  reg             lock_meta_reg;
  reg             lock_sync_reg;
  reg  [NPIN-1:0] pin_next;
  reg  [NPIN-1:0] oe_next;
  reg  [7:0]      rd_next;
  wire [4:0]      slot;
  wire            is_get;
  wire            req;
  wire [8:0]      maddr;
  wire [NPIN-1:0] pin_status;
  wire [NPIN-1:0] logic_out;
  integer         k;

  // map a command code onto its storage slot; get codes share the slot of set, except E1, which gets no slot
  function [4:0] slot_of;
    input [7:0] c;
    reg   [7:0] e;
    begin
      e = {c[7:1], 1'b0};
      slot_of = `DCU_S_NONE;
      case (e)
        `DCU_C_HORI_SET:  slot_of = `DCU_S_HORI;
        `DCU_C_VERT_SET:  slot_of = `DCU_S_VERT;
        `DCU_C_PCONF_SET: slot_of = `DCU_S_PCONF;
        `DCU_C_PVAL_SET:  slot_of = `DCU_S_PVAL;
        `DCU_C_POST_SET:  slot_of = `DCU_S_POST;
        `DCU_C_PWM_SET:   slot_of = `DCU_S_PWM;
        `DCU_C_ABC_SET:   slot_of = `DCU_S_ABC;
        `DCU_C_THR_SET:   slot_of = `DCU_S_THR;
        `DCU_C_PLL_SET:   slot_of = `DCU_S_PLL;
        `DCU_C_PCLK_SET:  slot_of = `DCU_S_PCLK;
        `DCU_C_FMT_SET:   slot_of = `DCU_S_FMT;
        `DCU_C_PLL_START: slot_of = (c[0]) ? `DCU_S_NONE : `DCU_S_START;
        default: begin
          if (e >= `DCU_C_GEN0_SET && e <= `DCU_C_GEN3_SET)
            slot_of = `DCU_S_GEN0 + {2'b00, e[3:1]};
          else if (e >= `DCU_C_LOGIC0_SET && e <= `DCU_C_LOGIC3_SET)
            slot_of = `DCU_S_GEN0 + {2'b00, e[3:1]};
        end
      endcase
    end
  endfunction

  assign slot   = slot_of(cmd_reg);
  assign is_get = cmd_reg[0];
  assign maddr  = {slot, idx_reg};
  assign req    = (avs_read_i | avs_write_i) & avs_waitrequest_o;

  // per-pin live status and raster logic of the generator outputs
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
      assign pin_status[gi] = dir_reg[gi] ? val_reg[gi] : pin_sync_reg[gi];
      assign logic_out[gi]  = fn_reg[gi][{gen_sig_i[sel_reg[gi][5:4]],
                                          gen_sig_i[sel_reg[gi][3:2]],
                                          gen_sig_i[sel_reg[gi][1:0]]}];
    end
  endgenerate

  always @* begin
    pin_next = val_reg;
    oe_next  = dir_reg;
    for (k = 0; k < NPIN; k = k + 1) begin
      // pin zero can be pulled back to general use by the second config byte
      if (panel_reg[k] && !(k == 0 && gen0_use_reg)) begin
        pin_next[k] = logic_out[k];
        oe_next[k]  = 1'b1;
      end
    end
  end

  always @* begin
    rd_next = `DCU_RST_BYTE;
    case (avs_address_i)
      `DCU_A_DATA: begin
        // the lock status code is even, so it cannot hang off the get bit
        if (cmd_reg == `DCU_C_PLL_STAT) begin
          rd_next = {7'h00, lock_sync_reg};
        end else if (is_get) begin
          if (cmd_reg == `DCU_C_PSTAT_GET)
            rd_next = {{(8-NPIN){1'b0}}, pin_status};
          else if (slot != `DCU_S_NONE)
            rd_next = pmem[maddr];
        end
      end
      `DCU_A_STAT: begin
        rd_next = 8'h00;
        rd_next[`DCU_ST_LOCK]    = lock_sync_reg;
        rd_next[`DCU_ST_PLL_EN]  = pll_en_o;
        rd_next[`DCU_ST_PLL_USE] = pll_sel_o;
        rd_next[`DCU_ST_DEEP]    = deep_sleep_o;
        rd_next[`DCU_ST_SLEEP]   = sleep_o;
      end
      default: rd_next = `DCU_RST_BYTE;
    endcase
  end

  // asynchronous inputs go through two flops before any use
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta_reg  <= {NPIN{1'b0}};
      pin_sync_reg  <= {NPIN{1'b0}};
      lock_meta_reg <= 1'b0;
      lock_sync_reg <= 1'b0;
    end else begin
      pin_meta_reg  <= gpio_in_i;
      pin_sync_reg  <= pin_meta_reg;
      lock_meta_reg <= pll_locked_i;
      lock_sync_reg <= lock_meta_reg;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gpio_o    <= {NPIN{1'b0}};
      gpio_oe_o <= {NPIN{1'b0}};
    end else begin
      gpio_o    <= pin_next;
      gpio_oe_o <= oe_next;
    end
  end

  // every request gets one waited cycle, then waitrequest drops for one cycle;
  // the store is updated in the waited cycle so the answer is already final
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= `DCU_RST_BYTE;
      cmd_reg           <= `DCU_RST_BYTE;
      idx_reg           <= 4'h0;
      panel_reg         <= {NPIN{1'b0}};
      dir_reg           <= {NPIN{1'b0}};
      gen0_use_reg      <= 1'b0;
      val_reg           <= {NPIN{1'b0}};
      pll_en_o          <= 1'b0;
      pll_sel_o         <= 1'b0;
      deep_sleep_o      <= 1'b0;
      sleep_o           <= 1'b0;
      pix_fmt_o         <= `DCU_RST_FMT;
      for (k = 0; k < NPIN; k = k + 1) begin
        sel_reg[k] <= 6'h00;
        fn_reg[k]  <= `DCU_RST_BYTE;
      end
      for (k = 0; k < MEMW; k = k + 1) begin
        pmem[k] <= `DCU_RST_BYTE;
      end
    end else begin
      avs_waitrequest_o <= ~req;
      if (req && avs_read_i) begin
        avs_readdata_o <= rd_next;
        // a data read steps through the bytes in write order
        if (avs_address_i == `DCU_A_DATA && is_get && idx_reg != 4'hf)
          idx_reg <= idx_reg + 4'h1;
      end
      if (req && avs_write_i && avs_address_i == `DCU_A_CMD) begin
        cmd_reg      <= avs_writedata_i;
        idx_reg      <= 4'h0;
        // any command write other than E5 is taken as the wake-up from deep sleep
        deep_sleep_o <= (avs_writedata_i == `DCU_C_DEEP_SLEEP);
        case (avs_writedata_i)
          `DCU_C_SLEEP_IN: begin
            sleep_o <= 1'b1;
            if (!gen0_use_reg && !panel_reg[0])
              val_reg[0] <= 1'b0;
          end
          `DCU_C_SLEEP_OUT: begin
            sleep_o <= 1'b0;
            if (!gen0_use_reg && !panel_reg[0])
              val_reg[0] <= 1'b1;
          end
          default: sleep_o <= sleep_o;
        endcase
      end
      if (req && avs_write_i && avs_address_i == `DCU_A_DATA && !is_get
          && slot != `DCU_S_NONE) begin
        // excess bytes beyond a slot overwrite its last byte, no wrap
        pmem[maddr] <= avs_writedata_i;
        if (idx_reg != 4'hf)
          idx_reg <= idx_reg + 4'h1;
        case (cmd_reg)
          `DCU_C_PCONF_SET: begin
            if (idx_reg == 4'h0) begin
              panel_reg <= avs_writedata_i[NPIN+3:4];
              dir_reg   <= avs_writedata_i[NPIN-1:0];
            end else if (idx_reg == 4'h1) begin
              gen0_use_reg <= avs_writedata_i[`DCU_F_GEN0_USE];
            end
          end
          `DCU_C_PVAL_SET: begin
            if (idx_reg == 4'h0)
              val_reg <= avs_writedata_i[NPIN-1:0];
          end
          `DCU_C_PLL_START: begin
            if (idx_reg == 4'h0) begin
              pll_en_o  <= avs_writedata_i[`DCU_F_PLL_EN];
              // the pll output is only taken once it runs and is locked
              pll_sel_o <= avs_writedata_i[`DCU_F_PLL_EN]
                           & avs_writedata_i[`DCU_F_PLL_USE]
                           & lock_sync_reg;
            end
          end
          `DCU_C_FMT_SET: begin
            if (idx_reg == 4'h0)
              pix_fmt_o <= avs_writedata_i[`DCU_F_FMT_MSB:0];
          end
          default: begin
            if (cmd_reg >= `DCU_C_LOGIC0_SET && cmd_reg <= `DCU_C_LOGIC3_SET) begin
              if (idx_reg == 4'h0)
                sel_reg[cmd_reg[2:1]] <= avs_writedata_i[5:0];
              else if (idx_reg == 4'h1)
                fn_reg[cmd_reg[2:1]]  <= avs_writedata_i;
            end
          end
        endcase
      end
    end
  end

endmodule // dcu_cmd_decoder

// ---- testbench/dcu_checker.sv ----
`timescale 1ns/1ns
module dcu_checker (
  input wire       clk_i,             // clock
  input wire       rst_i,             // reset
  input wire [1:0] avs_address_i,     // address
  input wire       avs_read_i,        // read
  input wire       avs_write_i,       // write
  input wire [7:0] avs_writedata_i,   // wdata
  input wire       avs_waitrequest_o, // wait
  input wire       pll_en_o,          // pll on
  input wire       pll_sel_o,         // pll clock
  input wire       deep_sleep_o,      // deep sleep
  input wire       sleep_o,           // sleep
  input wire [2:0] pix_fmt_o          // format
);
  logic [7:0] cmd_reg;
  wire        tk = (avs_read_i | avs_write_i) & avs_waitrequest_o;
  wire        cw = tk & avs_write_i & (avs_address_i == 2'h0);
  wire        dw = tk & avs_write_i & (avs_address_i == 2'h1);
  wire [2:0]  wf = avs_writedata_i[2:0];
  wire        w0 = avs_writedata_i[0];
  // mirror of the current command so data writes can be judged
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) cmd_reg <= 8'h00;
    else if (cw) cmd_reg <= avs_writedata_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ans; tk |=> !avs_waitrequest_o; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_one: assert property (p_one) else $error("long answer");
  property p_idle; !(avs_read_i | avs_write_i) && avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_deep; cw && avs_writedata_i == 8'he5 |=> deep_sleep_o; endproperty
  a_deep: assert property (p_deep) else $error("no deep sleep");
  property p_wake; deep_sleep_o && cw && avs_writedata_i != 8'he5 |=> !deep_sleep_o;
  endproperty
  a_wake: assert property (p_wake) else $error("deep sleep stuck");
  property p_sleep; cw && avs_writedata_i == 8'h10 |=> sleep_o; endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep");
  property p_fmt; dw && cmd_reg == 8'hf0 |=> pix_fmt_o == $past(wf); endproperty
  a_fmt: assert property (p_fmt) else $error("format wrong");
  property p_pll; dw && cmd_reg == 8'he0 |=> pll_en_o == $past(w0); endproperty
  a_pll: assert property (p_pll) else $error("pll enable wrong");
  property p_sel; pll_sel_o |-> pll_en_o; endproperty
  a_sel: assert property (p_sel) else $error("pll clock while off");
endmodule // dcu_checker
bind dcu_cmd_decoder dcu_checker dcu_checker_i (.clk_i(clk_i), .rst_i(rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_waitrequest_o(avs_waitrequest_o),
  .pll_en_o(pll_en_o), .pll_sel_o(pll_sel_o), .deep_sleep_o(deep_sleep_o),
  .sleep_o(sleep_o), .pix_fmt_o(pix_fmt_o));

// ---- testbench/dcu_far_model.sv ----
`timescale 1ns/1ns
module dcu_far_model #(
  parameter       LOCK_CYC = 20,
  parameter [3:0] PULL     = 4'ha
) (
  input  wire       clk_i,     // clock
  input  wire       rst_i,     // reset
  input  wire       pll_en_i,  // pll powered
  input  wire [3:0] pin_i,     // pin levels driven
  input  wire [3:0] pin_oe_i,  // pin enables
  output wire [3:0] pin_lvl_o, // resolved pin levels
  output logic [3:0] gen_o,    // generator outputs
  output logic       lock_o    // pll lock
);
  logic [7:0] cnt_reg;
  logic [7:0] lc_reg;
  // undriven pins sit at the board pull levels
  assign pin_lvl_o = (pin_oe_i & pin_i) | (~pin_oe_i & PULL);
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 8'h00;
      lc_reg  <= 8'h00;
      gen_o   <= 4'h0;
      lock_o  <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      if (cnt_reg[3:0] == 4'hf) gen_o <= gen_o + 4'h1;
      if (!pll_en_i) lc_reg <= 8'h00;
      else if (lc_reg != LOCK_CYC) lc_reg <= lc_reg + 8'h01;
      lock_o <= pll_en_i && (lc_reg == LOCK_CYC);
    end
  end
endmodule // dcu_far_model

// ---- testbench/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  logic clk_i = 0, rst_i = 1, r = 0, w = 0;
  logic [1:0] a = 2'h0;
  logic [7:0] d = 8'h00, t, q;
  logic [7:0] s [14] = '{8'hb4, 8'hb6, 8'hbc, 8'hbe, 8'hc0, 8'hc2, 8'hc4, 8'hc6,
                         8'hc8, 8'hce, 8'hd0, 8'hd4, 8'he2, 8'he6};
  wire wt, lk, pe, ps, ds, sl;
  wire [3:0] gi, go, goe, gs;
  wire [2:0] pf;
  int failures = 0, checks = 0, i, k;
  always #5 clk_i = ~clk_i;
  dcu_cmd_decoder dcu_cmd_decoder_i (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(a),
    .avs_read_i(r), .avs_write_i(w), .avs_writedata_i(d), .avs_readdata_o(q),
    .avs_waitrequest_o(wt), .gpio_in_i(gi), .gpio_o(go), .gpio_oe_o(goe), .gen_sig_i(gs),
    .pll_locked_i(lk), .pll_en_o(pe), .pll_sel_o(ps), .deep_sleep_o(ds), .sleep_o(sl),
    .pix_fmt_o(pf));
  dcu_far_model dcu_far_model_i (.clk_i(clk_i), .rst_i(rst_i), .pll_en_i(pe), .pin_i(go),
    .pin_oe_i(goe), .pin_lvl_o(gi), .gen_o(gs), .lock_o(lk));
  task stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task cmp(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task bus(input logic [1:0] ad, input logic we, input logic [7:0] dd);
    int n;
    @(posedge clk_i);
    a <= ad; w <= we; r <= !we; d <= dd;
    @(posedge clk_i);
    for (n = 0; n < 50 && wt !== 1'b0; n++) @(posedge clk_i);
    if (wt !== 1'b0) failures++;
    t = q;
    w <= 1'b0; r <= 1'b0;
  endtask
  task cmd(input logic [7:0] c); bus(2'h0, 1'b1, c); endtask
  task dat(input logic [7:0] v); bus(2'h1, 1'b1, v); endtask
  task chk(input logic [7:0] e); bus(2'h1, 1'b0, 8'h00); cmp(t, e); endtask
  task st(input logic [7:0] e); bus(2'h2, 1'b0, 8'h00); cmp(t, e); endtask
  task tick(input int n); repeat (n) @(posedge clk_i); #1; endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(1);
    cmp({ds, sl, pe, ps, goe}, 8'h00);
    cmp({1'b0, pf, go}, 8'h00);
    // every store/readback pair except B8, BA, CA, CC and F0, plus reading the set side and a spare byte
    for (i = 0; i < 14; i++) begin
      cmd(s[i]);
      for (k = 0; k < 3; k++) dat(s[i] ^ k);
      chk(8'h00);
      cmd(s[i] + 8'h01);
      for (k = 0; k < 3; k++) chk(s[i] ^ k);
      chk(8'h00);
    end
    bus(2'h3, 1'b0, 8'h00); cmp(t, 8'h00);
    cmd(8'hb8); dat(8'h03); dat(8'h00);
    cmd(8'hba); dat(8'h05);
    cmd(8'hbb); chk(8'h09);
    cmd(8'hb9); chk(8'h03); chk(8'h00);
    tick(2); cmp({goe, go & goe}, 8'h31);
    cmd(8'h10); tick(2); cmp({6'h0, sl, go[0]}, 8'h02);
    cmd(8'h11); tick(2); cmp({6'h0, sl, go[0]}, 8'h01);
    cmd(8'hb8); dat(8'h03); dat(8'h01);
    cmd(8'h10); tick(2); cmp({6'h0, sl, go[0]}, 8'h03);
    // pin one handed to the generators, logic follows input 0, then its inverse
    for (i = 0; i < 2; i++) begin
      cmd(8'hb8); dat(8'h22); dat(8'h00);
      cmd(8'hca); dat(8'h00); dat(i ? 8'h0f : 8'hf0);
      @(gs); tick(4); cmp({6'h0, goe[1], go[1]}, {6'h1, gs[0] ^ i[0]});
    end
    cmd(8'he0); dat(8'h01); tick(2); cmp({6'h0, ps, pe}, 8'h01);
    tick(30); st(8'h13);
    cmd(8'he4); chk(8'h01);
    cmd(8'he0); dat(8'h03); tick(2); cmp({6'h0, ps, pe}, 8'h03);
    cmd(8'hf0); dat(8'h05); tick(1); cmp({5'h0, pf}, 8'h05);
    cmd(8'hf1); chk(8'h05);
    cmd(8'he5); tick(1); st(8'h1f);
    bus(2'h2, 1'b1, 8'h00); st(8'h1f);
    cmd(8'h11); tick(1); st(8'h07);
    stop_test;
  end
  initial begin
    #100000;
    failures++;
    stop_test;
  end
endmodule // testbench
